// ===== include/ace_regs.svh
// Purpose: Addresses, flag positions, opcodes and cycle counts of the execution block
// Assumes: 8-bit register space, 16-bit program counter
// Notes: Shared by the block and its datapath leaf
`ifndef ACE_REGS_SVH
`define ACE_REGS_SVH

`define ACE_FLAGS_ADDR 8'hd5
`define ACE_SP_ADDR 8'hd9
`define ACE_WREG_BASE 8'h00
`define ACE_FLAGS_RESET 8'h00

`define ACE_FLAG_C 7
`define ACE_FLAG_Z 6
`define ACE_FLAG_S 5
`define ACE_FLAG_V 4
`define ACE_FLAG_C_MASK 8'h80

`define ACE_GRP_ADD 4'h0
`define ACE_GRP_ADC 4'h1
`define ACE_GRP_AND 4'h5
`define ACE_FORM_RR 4'h2
`define ACE_FORM_RIR 4'h3
`define ACE_FORM_MM 4'h4
`define ACE_FORM_MIR 4'h5
`define ACE_FORM_IMM 4'h6
`define ACE_OP_CLR_DIR 8'hb0
`define ACE_OP_CLR_IND 8'hb1
`define ACE_OP_CALL_DA 8'hf6
`define ACE_OP_CALL_IRR 8'hf4
`define ACE_OP_CCF 8'hef

`define ACE_CYC_SHORT 5'h04
`define ACE_CYC_LONG 5'h06
`define ACE_CYC_CALL_DA 5'h0e
`define ACE_CYC_CALL_IRR 5'h0c
`define ACE_CYC_ILLEGAL 5'h02
`define ACE_LEN_CALL_DA 16'h0003
`define ACE_LEN_CALL_IRR 16'h0002

`endif

// ===== include/ace_pkg.sv
// Purpose: Types of the arithmetic, logic and call execution block
// Assumes: Used through scoped names only
// Notes: State codes are one-hot
package ace_pkg;

   typedef enum logic [1:0] {
      ACE_ALU_ADD = 2'h0,
      ACE_ALU_ADC = 2'h1,
      ACE_ALU_AND = 2'h2
   } ace_alu_op_t;

   typedef enum logic [3:0] {
      ACE_ST_IDLE = 4'h1,
      ACE_ST_PUSH_LO = 4'h2,
      ACE_ST_PUSH_HI = 4'h4,
      ACE_ST_WAIT = 4'h8
   } ace_state_t;

endpackage

// ===== logic/ace_alu.sv
// Purpose: Combinational add, add with carry and AND with flag results
// Assumes: Flags byte laid out as in the register header
// Notes: Bits of the flags byte outside C, Z, S, V pass through
`timescale 1ns/100ps
`default_nettype none
`include "ace_regs.svh"

module ace_alu #(
   parameter int W = 8
) (
   input wire ace_pkg::ace_alu_op_t op,
   input wire logic [W-1:0] a,
   input wire logic [W-1:0] b,
   input wire logic [7:0] flags_in,
   output logic [W-1:0] result,
   output logic [7:0] flags_out
);

   wire logic cin;
   wire logic [W:0] sum;
   wire logic is_and;
   wire logic ovf;

   // Carry joins only the add-with-carry sum
   assign cin = (op == ace_pkg::ACE_ALU_ADC) ? flags_in[`ACE_FLAG_C] : 1'b0;
   assign sum = {1'b0, a} + {1'b0, b} + {{W{1'b0}}, cin};
   assign is_and = (op == ace_pkg::ACE_ALU_AND);
   assign result = is_and ? (a & b) : sum[W-1:0];
   assign ovf = (a[W-1] == b[W-1]) && (sum[W-1] != a[W-1]);

   always_comb begin
      flags_out = flags_in;
      flags_out[`ACE_FLAG_Z] = (result == {W{1'b0}});
      flags_out[`ACE_FLAG_S] = result[W-1];
      if (is_and) begin
         flags_out[`ACE_FLAG_V] = 1'b0;
      end else begin
         flags_out[`ACE_FLAG_C] = sum[W];
         flags_out[`ACE_FLAG_V] = ovf;
      end
   end

endmodule

`default_nettype wire

// ===== logic/ace_exec.sv
// Purpose: Executes add, add with carry, AND, call, carry inversion and clear
// Assumes: One instruction at a time, handed over with its bytes and its own address
// Notes: Holds the register space, flags and stack pointer inside it
//
// Decided for this implementation: strobed register access.
`timescale 1ns/100ps
`default_nettype none
`include "ace_regs.svh"

module ace_exec (
   input wire logic clock,
   input wire logic rstn,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic instr_start,
   input wire logic [7:0] instr_opcode,
   input wire logic [7:0] instr_byte1,
   input wire logic [7:0] instr_byte2,
   input wire logic [15:0] instr_pc,
   output logic instr_busy,
   output logic instr_done,
   output logic instr_illegal,
   output logic pc_load,
   output logic [15:0] pc_target,
   output logic stack_we,
   output logic [7:0] stack_addr,
   output logic [7:0] stack_wdata
);

   function automatic logic [7:0] ace_wreg(input logic [3:0] n);
      return `ACE_WREG_BASE + {4'h0, n};
   endfunction

   function automatic logic [4:0] ace_cycles(input logic [7:0] opc, input logic alu);
      if (alu) begin
         return (opc[3:0] == `ACE_FORM_RR) ? `ACE_CYC_SHORT : `ACE_CYC_LONG;
      end
      unique case (opc)
         `ACE_OP_CLR_DIR, `ACE_OP_CLR_IND, `ACE_OP_CCF: return `ACE_CYC_SHORT;
         `ACE_OP_CALL_DA: return `ACE_CYC_CALL_DA;
         `ACE_OP_CALL_IRR: return `ACE_CYC_CALL_IRR;
         default: return `ACE_CYC_ILLEGAL;
      endcase
   endfunction

   logic [7:0] regs [0:255];
   ace_pkg::ace_state_t state;
   logic [4:0] cnt;
   logic [15:0] ret_addr;
   logic call_pending;
   logic bad_pending;

   wire logic [3:0] grp;
   wire logic [3:0] form;
   wire logic is_alu;
   wire logic is_clr;
   wire logic is_ccf;
   wire logic is_call;
   wire logic start_ok;
   wire ace_pkg::ace_alu_op_t alu_op;
   wire logic [7:0] wdst;
   wire logic [7:0] wsrc;
   wire logic [7:0] src_addr;
   wire logic [7:0] src_val;
   wire logic [7:0] dst_addr;
   wire logic [7:0] dst_val;
   wire logic [7:0] clr_addr;
   wire logic [7:0] flags;
   wire logic [7:0] sp;
   wire logic [7:0] sp_dec;
   wire logic [7:0] alu_res;
   wire logic [7:0] alu_flags;
   wire logic [7:0] pair_low_addr;
   wire logic [15:0] call_target;
   wire logic [15:0] call_ret;
   wire logic pushing;
   wire logic exec_a_we;
   wire logic [7:0] exec_a_addr;
   wire logic [7:0] exec_a_data;
   wire logic a_we;
   wire logic [7:0] a_addr;
   wire logic [7:0] a_data;
   wire logic f_we;
   wire logic [7:0] f_data;

   assign grp = instr_opcode[7:4];
   assign form = instr_opcode[3:0];
   assign is_alu = (grp == `ACE_GRP_ADD || grp == `ACE_GRP_ADC || grp == `ACE_GRP_AND) &&
                   (form >= `ACE_FORM_RR) && (form <= `ACE_FORM_IMM);
   assign is_clr = (instr_opcode == `ACE_OP_CLR_DIR) || (instr_opcode == `ACE_OP_CLR_IND);
   assign is_ccf = (instr_opcode == `ACE_OP_CCF);
   assign is_call = (instr_opcode == `ACE_OP_CALL_DA) || (instr_opcode == `ACE_OP_CALL_IRR);
   assign start_ok = instr_start && (state == ace_pkg::ACE_ST_IDLE);
   assign alu_op = (grp == `ACE_GRP_ADC) ? ace_pkg::ACE_ALU_ADC :
                   (grp == `ACE_GRP_AND) ? ace_pkg::ACE_ALU_AND : ace_pkg::ACE_ALU_ADD;

   // Operand byte of the short forms: destination nibble high, source low
   assign wdst = ace_wreg(instr_byte1[7:4]);
   assign wsrc = ace_wreg(instr_byte1[3:0]);
   // Indirect forms read the pointer register, then the register it points to
   assign src_addr = (form == `ACE_FORM_RR) ? wsrc :
                     (form == `ACE_FORM_RIR) ? regs[wsrc] :
                     (form == `ACE_FORM_MM) ? instr_byte1 : regs[instr_byte1];
   assign src_val = (form == `ACE_FORM_IMM) ? instr_byte2 : regs[src_addr];
   assign dst_addr = (form == `ACE_FORM_RR || form == `ACE_FORM_RIR) ? wdst :
                     (form == `ACE_FORM_IMM) ? instr_byte1 : instr_byte2;
   assign dst_val = regs[dst_addr];
   assign clr_addr = (instr_opcode == `ACE_OP_CLR_IND) ? regs[instr_byte1] : instr_byte1;

   assign flags = regs[`ACE_FLAGS_ADDR];
   assign sp = regs[`ACE_SP_ADDR];
   assign sp_dec = sp - 8'h01;

   ace_alu #(
      .W(8)
   ) u_alu (
      .op(alu_op),
      .a(dst_val),
      .b(src_val),
      .flags_in(flags),
      .result(alu_res),
      .flags_out(alu_flags)
   );

   assign pair_low_addr = instr_byte1 + 8'h01;
   assign call_target = (instr_opcode == `ACE_OP_CALL_DA) ? {instr_byte1, instr_byte2} :
                        {regs[instr_byte1], regs[pair_low_addr]};
   assign call_ret = instr_pc + ((instr_opcode == `ACE_OP_CALL_DA) ?
                     `ACE_LEN_CALL_DA : `ACE_LEN_CALL_IRR);

   // Port A carries results, stack pointer updates or software writes
   assign pushing = (state == ace_pkg::ACE_ST_PUSH_LO) || (state == ace_pkg::ACE_ST_PUSH_HI);
   assign exec_a_we = (start_ok && (is_alu || is_clr)) || pushing;
   assign exec_a_addr = pushing ? `ACE_SP_ADDR : (is_clr ? clr_addr : dst_addr);
   assign exec_a_data = pushing ? sp_dec : (is_clr ? 8'h00 : alu_res);
   assign a_we = exec_a_we || reg_wr;
   assign a_addr = exec_a_we ? exec_a_addr : reg_addr;
   assign a_data = exec_a_we ? exec_a_data : reg_wdata;
   // Only arithmetic, AND and carry inversion update the flags; a clear aimed at the flags address zeroes them over port A
   assign f_we = start_ok && (is_alu || is_ccf);
   assign f_data = is_ccf ? (flags ^ `ACE_FLAG_C_MASK) : alu_flags;

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < 256; i++) begin
            regs[i] <= 8'h00;
         end
      end else begin
         // A result aimed at the flags address overrides the flag update
         if (f_we && !(a_we && a_addr == `ACE_FLAGS_ADDR)) begin
            regs[`ACE_FLAGS_ADDR] <= f_data;
         end
         if (a_we) begin
            regs[a_addr] <= a_data;
         end
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         reg_rdata <= 8'h00;
      end else begin
         reg_rdata <= reg_rd ? regs[reg_addr] : 8'h00;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         state <= ace_pkg::ACE_ST_IDLE;
         cnt <= 5'h00;
         ret_addr <= 16'h0000;
         call_pending <= 1'b0;
         bad_pending <= 1'b0;
         instr_busy <= 1'b0;
         instr_done <= 1'b0;
         instr_illegal <= 1'b0;
         pc_load <= 1'b0;
         pc_target <= 16'h0000;
         stack_we <= 1'b0;
         stack_addr <= 8'h00;
         stack_wdata <= 8'h00;
      end else begin
         instr_done <= 1'b0;
         instr_illegal <= 1'b0;
         pc_load <= 1'b0;
         stack_we <= 1'b0;
         if (state != ace_pkg::ACE_ST_IDLE) begin
            cnt <= cnt - 5'h01;
         end
         unique case (state)
            ace_pkg::ACE_ST_IDLE: begin
               if (instr_start) begin
                  cnt <= ace_cycles(instr_opcode, is_alu) - 5'h01;
                  instr_busy <= 1'b1;
                  call_pending <= is_call;
                  bad_pending <= !(is_alu || is_clr || is_ccf || is_call);
                  if (is_call) begin
                     ret_addr <= call_ret;
                     pc_target <= call_target;
                     state <= ace_pkg::ACE_ST_PUSH_LO;
                  end else begin
                     state <= ace_pkg::ACE_ST_WAIT;
                  end
               end
            end
            ace_pkg::ACE_ST_PUSH_LO: begin
               stack_we <= 1'b1;
               stack_addr <= sp_dec;
               stack_wdata <= ret_addr[7:0];
               state <= ace_pkg::ACE_ST_PUSH_HI;
            end
            ace_pkg::ACE_ST_PUSH_HI: begin
               stack_we <= 1'b1;
               stack_addr <= sp_dec;
               stack_wdata <= ret_addr[15:8];
               state <= ace_pkg::ACE_ST_WAIT;
            end
            ace_pkg::ACE_ST_WAIT: begin
               if (cnt == 5'h01) begin
                  instr_done <= 1'b1;
                  instr_illegal <= bad_pending;
                  pc_load <= call_pending;
                  instr_busy <= 1'b0;
                  state <= ace_pkg::ACE_ST_IDLE;
               end
            end
         endcase
      end
   end

   wire logic plain_dst;
   assign plain_dst = (dst_addr != `ACE_FLAGS_ADDR) && (dst_addr != `ACE_SP_ADDR);

   adc_sum_a: assert property (@(posedge clock) disable iff (!rstn)
      start_ok && is_alu && grp == `ACE_GRP_ADC && plain_dst |=>
      regs[$past(dst_addr)] == 8'($past(dst_val) + $past(src_val) +
      {7'h00, $past(flags[`ACE_FLAG_C])}))
      else $error("add with carry result wrong");

   adc_short_time_a: assert property (@(posedge clock) disable iff (!rstn)
      start_ok && instr_opcode == 8'h12 |=> !instr_done [*3] ##1 instr_done)
      else $error("short add with carry not done in 4 cycles");

   add_long_time_a: assert property (@(posedge clock) disable iff (!rstn)
      start_ok && instr_opcode == 8'h04 |=> !instr_done [*5] ##1 instr_done)
      else $error("long add not done in 6 cycles");

   add_carry_a: assert property (@(posedge clock) disable iff (!rstn)
      start_ok && is_alu && grp == `ACE_GRP_ADD && plain_dst |=>
      flags[`ACE_FLAG_C] == $past(9'({1'b0, dst_val} + {1'b0, src_val}) >> 8))
      else $error("carry flag wrong after add");

   add_overflow_a: assert property (@(posedge clock) disable iff (!rstn)
      start_ok && is_alu && grp == `ACE_GRP_ADD && plain_dst |=>
      flags[`ACE_FLAG_V] == (($past(dst_val[7]) == $past(src_val[7])) &&
      (regs[$past(dst_addr)][7] != $past(dst_val[7]))))
      else $error("overflow flag wrong after add");

   and_flags_a: assert property (@(posedge clock) disable iff (!rstn)
      start_ok && is_alu && grp == `ACE_GRP_AND && plain_dst |=>
      !flags[`ACE_FLAG_V] && flags[`ACE_FLAG_C] == $past(flags[`ACE_FLAG_C]) &&
      flags[`ACE_FLAG_Z] == ($past(dst_val & src_val) == 8'h00))
      else $error("flags wrong after AND");

   call_push_a: assert property (@(posedge clock) disable iff (!rstn)
      state == ace_pkg::ACE_ST_PUSH_LO |=> stack_we && stack_addr == $past(sp) - 8'h01 &&
      stack_wdata == ret_addr[7:0] ##1 stack_we && stack_addr == $past(sp, 2) - 8'h02 &&
      stack_wdata == ret_addr[15:8])
      else $error("call push sequence wrong");

   call_da_time_a: assert property (@(posedge clock) disable iff (!rstn)
      start_ok && instr_opcode == `ACE_OP_CALL_DA |-> ##14 instr_done && pc_load &&
      pc_target == $past({instr_byte1, instr_byte2}, 14))
      else $error("direct call timing or target wrong");

   call_ret_a: assert property (@(posedge clock) disable iff (!rstn)
      start_ok && instr_opcode == `ACE_OP_CALL_IRR |=> ret_addr == $past(instr_pc) + 16'h0002)
      else $error("indirect call return address wrong");

   ccf_invert_a: assert property (@(posedge clock) disable iff (!rstn)
      start_ok && is_ccf |=> flags == ($past(flags) ^ `ACE_FLAG_C_MASK))
      else $error("carry inversion wrong");

   clr_keep_a: assert property (@(posedge clock) disable iff (!rstn)
      start_ok && is_clr && clr_addr != `ACE_FLAGS_ADDR && !reg_wr |=>
      regs[$past(clr_addr)] == 8'h00 && $stable(flags))
      else $error("clear wrong or flags touched");

endmodule

`default_nettype wire

// ===== sim/ace_stack_mem.sv
// Purpose: Stack memory on the far side of the push port of the execution block
// Assumes: One byte written per strobe, no read side needed by the block
// Notes: Counts writes and keeps the last address, so push order can be judged
`timescale 1ns/100ps
`default_nettype none
module ace_stack_mem (
   input wire logic clock,
   input wire logic rstn,
   input wire logic stack_we,
   input wire logic [7:0] stack_addr,
   input wire logic [7:0] stack_wdata,
   input wire logic [7:0] peek_addr,
   output logic [7:0] peek_data,
   output logic [7:0] last_addr,
   output logic [7:0] wr_count
);
   logic [7:0] mem [0:255];
   assign peek_data = mem[peek_addr];
   always_ff @(posedge clock) begin
      if (stack_we) begin
         mem[stack_addr] <= stack_wdata;
      end
   end
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         wr_count <= 8'h00;
         last_addr <= 8'h00;
      end else if (stack_we) begin
         wr_count <= wr_count + 8'h01;
         last_addr <= stack_addr;
      end
   end
endmodule
`default_nettype wire

// ===== sim/ace_exec_bench.sv
// Purpose: Self-checking bench of the arithmetic, logic and call execution block
// Assumes: Register port with one-cycle read data, one instruction at a time
// Notes: Expected results and flags are computed here from the operands
`timescale 1ns/100ps
`default_nettype none
module ace_exec_bench;
   logic clock, rstn, reg_wr, reg_rd, instr_start;
   logic instr_busy, instr_done, instr_illegal, pc_load, stack_we;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, instr_opcode, instr_byte1, instr_byte2;
   logic [7:0] stack_addr, stack_wdata, peek_addr, peek_data, last_addr, wr_count;
   logic [15:0] instr_pc, pc_target;
   logic [7:0] m [0:3];
   int num_errors = 0;
   int num_checks = 0;
   int cycles = 0;
   // Operand table: opcode, byte1, byte2, regs 01..03, flags before
   logic [55:0] alu_tab [20] = '{
      56'h02_12_00_12_03_0a_00, 56'h03_12_00_12_03_0a_00, 56'h04_02_01_21_03_0a_0f,
      56'h05_02_01_21_03_0a_00, 56'h06_01_25_21_03_0a_00, 56'h12_12_00_10_03_0a_80,
      56'h13_12_00_10_03_0a_80, 56'h14_02_01_20_03_0a_80, 56'h15_02_01_20_03_0a_80,
      56'h16_01_11_20_03_0a_80, 56'h52_12_00_12_03_0a_80, 56'h53_12_00_12_03_0a_f0,
      56'h54_02_01_21_03_0a_80, 56'h55_02_01_21_03_0a_00, 56'h56_01_25_21_03_0a_70,
      56'h06_01_01_7f_03_0a_00, 56'h06_01_01_ff_03_0a_00, 56'h16_01_7f_00_03_0a_80,
      56'h12_12_00_80_80_0a_00, 56'h54_02_01_f0_0f_0a_8f};

   ace_exec ace_exec_i (.clock, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .instr_start, .instr_opcode, .instr_byte1, .instr_byte2, .instr_pc, .instr_busy,
      .instr_done, .instr_illegal, .pc_load, .pc_target, .stack_we, .stack_addr,
      .stack_wdata);
   ace_stack_mem ace_stack_mem_i (.clock, .rstn, .stack_we, .stack_addr, .stack_wdata,
      .peek_addr, .peek_data, .last_addr, .wr_count);

   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic end_sim();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   always @(posedge clock) begin
      cycles++;
      if (cycles == 5000) begin
         num_errors++;
         end_sim();
      end
   end

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask

   task automatic chk_rd(input string name, input logic [7:0] a, input logic [7:0] e);
      @(posedge clock);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 check(name, {8'h00, reg_rdata}, {8'h00, e});
   endtask

   task automatic run(input logic [7:0] o, input logic [7:0] x, input logic [7:0] y,
         input logic [15:0] pc, input int n_exp, input logic ill, input logic call);
      int n;
      @(posedge clock);
      instr_start <= 1'b1;
      instr_opcode <= o;
      instr_byte1 <= x;
      instr_byte2 <= y;
      instr_pc <= pc;
      @(posedge clock);
      instr_start <= 1'b0;
      // Cycle 1 after the start cycle: busy already up, done not yet
      #1 check("busy", {15'h0000, instr_busy}, 16'h0001);
      n = 1;
      while (instr_done !== 1'b1 && n < 40) begin
         @(posedge clock);
         #1 n++;
      end
      check("cycles", n[15:0], n_exp[15:0]);
      check("illegal", {15'h0000, instr_illegal}, {15'h0000, ill});
      check("pc_load", {15'h0000, pc_load}, {15'h0000, call});
   endtask

   task automatic test_alu();
      logic [7:0] o, x, y, f, a, b, res, dst, fl;
      logic [8:0] sum;
      foreach (alu_tab[i]) begin
         {o, x, y, m[1], m[2], m[3], f} = alu_tab[i];
         m[0] = 8'h00;
         for (int k = 0; k < 4; k++) wr(k[7:0], m[k]);
         wr(8'hd5, f);
         case (o[3:0])
            4'h2: begin dst = {4'h0, x[7:4]}; b = m[x[1:0]]; end
            4'h3: begin dst = {4'h0, x[7:4]}; b = m[m[x[1:0]][1:0]]; end
            4'h4: begin dst = y; b = m[x[1:0]]; end
            4'h5: begin dst = y; b = m[m[x[1:0]][1:0]]; end
            default: begin dst = x; b = y; end
         endcase
         a = m[dst[1:0]];
         sum = {1'b0, a} + {1'b0, b} + {8'h00, (o[7:4] == 4'h1) & f[7]};
         if (o[7:4] == 4'h5) begin
            res = a & b;
            fl = {f[7], res == 8'h00, res[7], 1'b0, f[3:0]};
         end else begin
            res = sum[7:0];
            fl = {sum[8], res == 8'h00, res[7], (a[7] == b[7]) && (res[7] != a[7]), f[3:0]};
         end
         run(o, x, y, 16'h0100, (o[3:0] == 4'h2) ? 4 : 6, 1'b0, 1'b0);
         m[dst[1:0]] = res;
         for (int k = 0; k < 4; k++) chk_rd("alu_reg", k[7:0], m[k]);
         chk_rd("alu_flags", 8'hd5, fl);
      end
   endtask

   task automatic test_call();
      logic [15:0] ret;
      wr(8'h00, 8'h15);
      wr(8'h01, 8'h21);
      wr(8'hd5, 8'ha5);
      for (int i = 0; i < 2; i++) begin
         wr(8'hd9, 8'hb2);
         run(i ? 8'hf4 : 8'hf6, i ? 8'h00 : 8'h15, 8'h21, 16'h1a47, i ? 12 : 14, 1'b0, 1'b1);
         ret = 16'h1a47 + (i ? 16'h0002 : 16'h0003);
         check("target", pc_target, 16'h1521);
         peek_addr = 8'hb1;
         #1 check("ret_low", {8'h00, peek_data}, {8'h00, ret[7:0]});
         peek_addr = 8'hb0;
         #1 check("ret_high", {8'h00, peek_data}, {8'h00, ret[15:8]});
         check("last_push", {8'h00, last_addr}, 16'h00b0);
         check("pushes", {8'h00, wr_count}, 16'(2 * (i + 1)));
         chk_rd("sp", 8'hd9, 8'hb0);
         chk_rd("call_flags", 8'hd5, 8'ha5);
      end
   endtask

   task automatic test_inv_zero();
      wr(8'hd5, 8'h3c);
      run(8'hef, 8'h00, 8'h00, 16'h0200, 4, 1'b0, 1'b0);
      chk_rd("inv_once", 8'hd5, 8'hbc);
      run(8'hef, 8'h00, 8'h00, 16'h0201, 4, 1'b0, 1'b0);
      chk_rd("inv_twice", 8'hd5, 8'h3c);
      wr(8'h00, 8'h4f);
      wr(8'h01, 8'h02);
      wr(8'h02, 8'h5e);
      run(8'hb0, 8'h00, 8'h00, 16'h0300, 4, 1'b0, 1'b0);
      run(8'hb1, 8'h01, 8'h00, 16'h0302, 4, 1'b0, 1'b0);
      chk_rd("zero_dir", 8'h00, 8'h00);
      chk_rd("pointer", 8'h01, 8'h02);
      chk_rd("zero_ind", 8'h02, 8'h00);
      chk_rd("zero_flags", 8'hd5, 8'h3c);
      run(8'hff, 8'h01, 8'h00, 16'h0304, 2, 1'b1, 1'b0);
      chk_rd("no_change", 8'h01, 8'h02);
   endtask

   initial begin
      rstn = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      instr_start = 1'b0;
      instr_opcode = 8'h00;
      instr_byte1 = 8'h00;
      instr_byte2 = 8'h00;
      instr_pc = 16'h0000;
      peek_addr = 8'h00;
      repeat (5) @(posedge clock);
      rstn <= 1'b1;
      chk_rd("flags_reset", 8'hd5, 8'h00);
      @(posedge clock);
      #1 check("rdata_idle", {8'h00, reg_rdata}, 16'h0000);
      test_alu();
      test_call();
      test_inv_zero();
      end_sim();
   end
endmodule
`default_nettype wire
